// >>> sadc_device.sv
// converter end: frame sequencing, serial output and power control
// What this block does
// - msb first after one leading zero
// - trailing zeros: three, five or seven
// - sample at frame select fall, sclk steps
// - one result bit per sclk cycle
// - msb shown in second cycle
// - lsb in cycle 13, 11 or 9
// - output released in sixteenth cycle
// - host may start next frame right away
// - straight binary codes, half lsb transitions
// - select low through tenth fall keeps power
// - early release aborts, tristates, powers down
// - host raises select between falls 2-10
// - dummy frame of ten cycles wakes up
// - frame after dummy gives valid result
// - wake time equals dummy frame length
// - host picks sclk rate for full speed
// - output changes on sclk falling edges
// - channel pick changes in cycles 2-12; device reads the pick only at frame select fall
`include "sadc_regs.svh"
module sadc_device
  import sadc_pkg::*;
#(
  parameter int RES = 12
) (
  input  wire logic           sys_clk,         // clock
  input  wire logic           reset,           // sync reset
  sadc_link_if.device         link,            // serial link
  input  wire logic [RES-1:0] sample_one,      // code from input one
  input  wire logic [RES-1:0] sample_two,      // code from input two
  output logic                powered,         // normal mode flag
  output logic                result_valid,    // frame data is valid
  output logic [RES-1:0]      sampled_code     // code held this frame
);
  localparam int LSB_CYC = RES + 1;
  // ****************************************
  // synchronisers and edge detect
  // ****************************************
  logic [1:0] cs_sync;
  logic [1:0] ck_sync;
  logic [1:0] ch_sync;
  logic       cs_d;
  logic       ck_d;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h3;
      ch_sync <= 2'h0;
      cs_d    <= 1'b1;
      ck_d    <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], link.frame_sel_n};
      ck_sync <= {ck_sync[0], link.sclk};
      ch_sync <= {ch_sync[0], link.input_channel_pick};
      cs_d    <= cs_sync[1];
      ck_d    <= ck_sync[1];
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  assign cs_fall = cs_d & ~cs_sync[1];
  assign cs_rise = ~cs_d & cs_sync[1];
  assign ck_fall = ck_d & ~ck_sync[1] & ~cs_sync[1];
  // ****************************************
  // frame sequencing
  // ****************************************
  sadc_state_e state;
  logic [4:0]  fall_cnt;
  logic        dummy;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state    <= SADC_IDLE;
      fall_cnt <= 5'h00;
    end else begin
      unique case (state)
        SADC_IDLE: begin
          if (cs_fall) begin
            state    <= SADC_FRAME;
            fall_cnt <= 5'h00;
          end
        end
        SADC_FRAME: begin
          if (cs_rise) begin
            state <= SADC_IDLE;
          end else if (ck_fall) begin
            fall_cnt <= fall_cnt + 5'h01;
            if (fall_cnt == 5'(`SADC_FRAME_CYCLES - 1)) begin
              state <= SADC_DONE;
            end
          end
        end
        SADC_DONE: begin
          if (cs_rise) begin
            state <= SADC_IDLE;
          end
        end
      endcase
    end
  end
  // ****************************************
  // power control
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      powered <= 1'b1;
      dummy   <= 1'b0;
    end else if (cs_rise && state == SADC_FRAME) begin
      if (fall_cnt < 5'(`SADC_PD_EDGE)) begin
        powered <= 1'b0;
        dummy   <= 1'b0;
      end else begin
        powered <= 1'b1;
        dummy   <= 1'b0;
      end
    end else if (cs_fall && !powered) begin
      dummy <= 1'b1;
    end else if (state == SADC_FRAME && dummy && ck_fall
                 && fall_cnt == 5'(`SADC_WAKE_MIN_CYC - 1)) begin
      powered <= 1'b1;
    end
  end
  // ****************************************
  // sample and serial output
  // ****************************************
  logic [15:0] shreg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sampled_code <= '0;
      result_valid <= 1'b0;
      shreg        <= 16'h0000;
    end else if (cs_fall) begin
      // straight binary, channel picked at the sampling instant
      sampled_code <= ch_sync[1] ? sample_two : sample_one;
      result_valid <= powered;
      // leading zero, msb first, trailing zeros fill to sixteen
      shreg <= 16'({1'b0, (ch_sync[1] ? sample_two : sample_one)}) << (15 - RES);
    end else if (state == SADC_FRAME && ck_fall) begin
      shreg <= {shreg[14:0], 1'b0};
    end
  end
  assign link.dout_o  = shreg[15];
  assign link.dout_oe = (state == SADC_FRAME) && !(cs_rise);
  logic unused_lsb;
  assign unused_lsb = (LSB_CYC == 0);
endmodule

// >>> sadc_fifo.sv
// small valid/ready fifo for conversion results
module sadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,   // clock
  input  wire logic             reset,     // sync reset
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // not full
  output logic [WIDTH-1:0]      out_data,  // head data
  output logic                  out_valid, // not empty
  input  wire logic             out_ready  // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> sadc_host.sv
// host end: generates frames and serial clock, collects results
`include "sadc_regs.svh"
module sadc_host
  import sadc_pkg::*;
#(
  parameter int RES = 12
) (
  input  wire logic           sys_clk,      // clock
  input  wire logic           reset,        // sync reset
  sadc_link_if.host           link,         // serial link
  input  wire logic           start,        // begin a frame
  input  wire logic           power_down,   // abort frame early
  input  wire logic           channel,      // input channel for next frame
  output logic                busy,         // frame in progress
  output logic [RES-1:0]      res_data,     // fifo head result
  output logic                res_valid,    // result available
  input  wire logic           res_ready     // result consumed
);
  sadc_hstate_e     state;
  logic [7:0]       div_cnt;
  logic [4:0]       cyc;
  logic [15:0]      rx;
  logic [1:0]       din_sync;
  logic             push;
  logic             fifo_ready;
  logic [RES-1:0]   word;
  logic             pd_frame;
  assign busy = (state != SADC_H_IDLE);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      din_sync <= 2'h3;
    end else begin
      din_sync <= {din_sync[0], link.dout_wire};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state                   <= SADC_H_IDLE;
      div_cnt                 <= 8'h00;
      cyc                     <= 5'h00;
      rx                      <= 16'h0000;
      push                    <= 1'b0;
      pd_frame                <= 1'b0;
      link.frame_sel_n        <= 1'b1;
      link.sclk               <= 1'b1;
      link.input_channel_pick <= 1'b0;
    end else begin
      push <= 1'b0;
      unique case (state)
        SADC_H_IDLE: begin
          if (start && fifo_ready) begin
            state                   <= SADC_H_RUN;
            link.frame_sel_n        <= 1'b0;
            link.input_channel_pick <= channel;
            pd_frame                <= power_down;
            div_cnt                 <= 8'h00;
            cyc                     <= 5'h00;
          end
        end
        SADC_H_RUN: begin
          if (div_cnt == 8'(`SADC_SCLK_HALF_CYC - 1)) begin
            div_cnt   <= 8'h00;
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
              // rising edge: sample data shown before the previous fall (link sync delay)
              rx <= {rx[14:0], din_sync[1]};
            end else begin
              cyc <= cyc + 5'h01;
              if (pd_frame && cyc == 5'(`SADC_MSB_CYCLE + 2)) begin
                link.frame_sel_n <= 1'b1;
                state            <= SADC_H_GAP;
              end else if (cyc == 5'(`SADC_FRAME_CYCLES - 1)) begin
                link.frame_sel_n <= 1'b1;
                push             <= 1'b1;
                state            <= SADC_H_GAP;
              end
            end
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        SADC_H_GAP: begin
          link.sclk <= 1'b1;
          div_cnt   <= div_cnt + 8'h01;
          if (div_cnt == 8'(`SADC_GAP_CYC)) begin
            state <= SADC_H_IDLE;
          end
        end
        default: state <= SADC_H_IDLE;
      endcase
    end
  end
  // fifteen rises per frame: rx[14] holds the leading zero, msb follows
  assign word = rx[13 -: RES];
  sadc_fifo #(.WIDTH(RES), .DEPTH(4)) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (word),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (res_data),
    .out_valid (res_valid),
    .out_ready (res_ready)
  );
endmodule

// >>> sadc_link_if.sv
// four wire serial link between host and converter
interface sadc_link_if;
  logic frame_sel_n;
  logic sclk;
  logic input_channel_pick;
  logic dout_o;
  logic dout_oe;
  logic dout_wire;
  assign dout_wire = dout_oe ? dout_o : 1'b1;
  modport device (
    input  frame_sel_n,
    input  sclk,
    input  input_channel_pick,
    output dout_o,
    output dout_oe
  );
  modport host (
    output frame_sel_n,
    output sclk,
    output input_channel_pick,
    input  dout_wire
  );
endinterface

// >>> sadc_link_monitor.sv
// assertion checker beside the serial adc link
module sadc_link_monitor #(
  parameter int RES = 12
) (
  input wire logic sys_clk,            // clock
  input wire logic reset,              // sync reset
  input wire logic frame_sel_n,        // frame select
  input wire logic sclk,               // serial clock
  input wire logic input_channel_pick, // channel pick
  input wire logic dout_o,             // device data
  input wire logic dout_oe,            // device drive enable
  input wire logic dout_wire           // resolved data line
);
  logic       sclk_q;
  logic       fall;
  logic [4:0] cnt;
  logic [5:0] fall_sh;
  assign fall = sclk_q & ~sclk;
  always_ff @(posedge sys_clk) sclk_q <= reset ? 1'b1 : sclk;
  // sclk falls seen in the current frame
  always_ff @(posedge sys_clk) cnt <= (reset || frame_sel_n) ? 5'h00 : cnt + 5'(fall);
  always_ff @(posedge sys_clk) fall_sh <= reset ? 6'h00 : {fall_sh[4:0], fall};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_lead; fall && cnt == 5'h00 && dout_oe |-> !dout_wire; endproperty
  a_lead: assert property (p_lead) else $error("leading bit not zero");
  property p_trail;
    fall && cnt >= 5'(RES + 1) && cnt <= 5'h0E && dout_oe |-> !dout_o;
  endproperty
  a_trail: assert property (p_trail) else $error("trailing bit not zero");
  property p_start; $rose(dout_oe) |-> !frame_sel_n; endproperty
  a_start: assert property (p_start) else $error("drive outside frame");
  property p_change; dout_oe && $past(dout_oe) && $changed(dout_o) |-> |fall_sh; endproperty
  a_change: assert property (p_change) else $error("data moved without sclk fall");
  property p_release; fall && cnt == 5'h0F |-> ##[1:10] !dout_oe; endproperty
  a_release: assert property (p_release) else $error("no release at frame end");
  property p_abort; $rose(frame_sel_n) |-> ##[1:5] !dout_oe; endproperty
  a_abort: assert property (p_abort) else $error("drive kept after select rise");
  property p_idle; frame_sel_n [*6] |-> !dout_oe; endproperty
  a_idle: assert property (p_idle) else $error("drive while deselected");
  property p_host_end; fall && cnt == 5'h0F |-> ##[1:15] frame_sel_n; endproperty
  a_host_end: assert property (p_host_end) else $error("frame not closed");
  property p_pd_window; $rose(frame_sel_n) |-> cnt >= 5'h02; endproperty
  a_pd_window: assert property (p_pd_window) else $error("select rose too early");
  c_full: cover property (fall && cnt == 5'h0F);
  c_abort: cover property ($rose(frame_sel_n) && cnt < 5'h0A);
  c_drive: cover property ($rose(dout_oe) && !input_channel_pick);
endmodule

// >>> sadc_pkg.sv
// state types for the two ends of the serial adc link, one enum per end
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_IDLE  = 3'b001,
    SADC_FRAME = 3'b010,
    SADC_DONE  = 3'b100
  } sadc_state_e;
  typedef enum logic [2:0] {
    SADC_H_IDLE = 3'b001,
    SADC_H_RUN  = 3'b010,
    SADC_H_GAP  = 3'b100
  } sadc_hstate_e;
endpackage

// >>> sadc_regs.svh
// constants for the serial adc frame and power control block
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
// ****************************************
// frame layout
// ****************************************
`define SADC_FRAME_CYCLES   16
`define SADC_PD_EDGE        10
`define SADC_MSB_CYCLE      2
`define SADC_WAKE_MIN_CYC   10
`define SADC_INPUT_CHANNEL_PICK_FIRST    2
`define SADC_INPUT_CHANNEL_PICK_LAST     12
// ****************************************
// link timing
// ****************************************
`define SADC_SYS_PERIOD_PS  4000
`define SADC_SCLK_HALF_NS   12
`define SADC_SCLK_HALF_CYC  ((`SADC_SCLK_HALF_NS * 1000) / `SADC_SYS_PERIOD_PS)
`define SADC_GAP_CYC        4
`endif

// >>> serial_adc_frame_and_power_control_tb.sv
// testbench joining host and device ends of the serial adc link
module serial_adc_frame_and_power_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic        power_down = 1'b0;
  logic        channel = 1'b0;
  logic        res_ready = 1'b0;
  logic [11:0] sample_one = 12'h000;
  logic [11:0] sample_two = 12'h000;
  logic        powered, result_valid, busy, res_valid;
  logic [11:0] sampled_code, res_data;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  sadc_link_if link ();
  sadc_device #(.RES(12)) u_sadc_device (.sys_clk(sys_clk), .reset(reset), .link(link),
    .sample_one(sample_one), .sample_two(sample_two), .powered(powered),
    .result_valid(result_valid), .sampled_code(sampled_code));
  sadc_host #(.RES(12)) u_sadc_host (.sys_clk(sys_clk), .reset(reset), .link(link),
    .start(start), .power_down(power_down), .channel(channel), .busy(busy),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready));
  sadc_link_monitor #(.RES(12)) u_sadc_link_monitor (.sys_clk(sys_clk), .reset(reset),
    .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
    .input_channel_pick(link.input_channel_pick), .dout_o(link.dout_o),
    .dout_oe(link.dout_oe), .dout_wire(link.dout_wire));
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // start one frame, hold start until taken, wait for idle
  task automatic frame(input logic ch, input logic pd);
    int n;
    n = 0;
    @(posedge sys_clk);
    start <= 1'b1;
    channel <= ch;
    power_down <= pd;
    do @(negedge sys_clk); while (busy !== 1'b1 && ++n < 50);
    @(posedge sys_clk) start <= 1'b0;
    n = 0;
    do @(negedge sys_clk); while (busy !== 1'b0 && ++n < 400);
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic pop(output logic [11:0] got);
    int n;
    n = 0;
    do @(negedge sys_clk); while (res_valid !== 1'b1 && ++n < 20);
    got = res_data;
    @(posedge sys_clk) res_ready <= 1'b1;
    @(posedge sys_clk) res_ready <= 1'b0;
  endtask
  initial begin
    logic [11:0] got;
    logic [11:0] tbl [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h3F1};
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk({11'h000, powered}, 12'h001);
    // fill the fifo while the reader stalls, both channels
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sample_one <= i[0] ? ~tbl[i] : tbl[i];
      sample_two <= i[0] ? tbl[i] : ~tbl[i];
      frame(i[0], 1'b0);
      chk(sampled_code, tbl[i]);
      chk({10'h000, result_valid, powered}, 12'h003);
    end
    frame(1'b0, 1'b0);
    chk({11'h000, busy}, 12'h000);
    foreach (tbl[i]) begin
      pop(got);
      chk(got, tbl[i]);
    end
    @(negedge sys_clk);
    chk({11'h000, res_valid}, 12'h000);
    // power down, dummy wake frame, then a valid frame
    frame(1'b0, 1'b1);
    chk({10'h000, powered, busy}, 12'h000);
    @(posedge sys_clk) sample_one <= 12'h5A3;
    frame(1'b0, 1'b0);
    chk({10'h000, result_valid, powered}, 12'h001);
    frame(1'b0, 1'b0);
    chk({10'h000, result_valid, powered}, 12'h003);
    chk(sampled_code, 12'h5A3);
    do begin
      pop(got);
      @(negedge sys_clk);
    end while (res_valid === 1'b1);
    chk(got, 12'h5A3);
    stop_test();
  end
endmodule
